// ==== hdl/bfiu_regs.svh ====
// Register offsets, field positions, reset values and cycle counts of the bit/flag unit
`ifndef BFIU_REGS_SVH
`define BFIU_REGS_SVH

// Byte offsets on the register bus
`define BFIU_CMD_OFS       8'h00
`define BFIU_OPERAND_OFS   8'h04
`define BFIU_IOVAL_OFS     8'h08
`define BFIU_STATUS_OFS    8'h0c
`define BFIU_STATE_OFS     8'h10

// Command word fields
`define BFIU_CMD_OP_LSB    0
`define BFIU_CMD_OP_MSB    4
`define BFIU_CMD_BIT_LSB   8
`define BFIU_CMD_BIT_MSB   10
`define BFIU_CMD_SRAM_BIT  12
`define BFIU_CMD_EXT_BIT   13

// State word fields
`define BFIU_ST_CYC_LSB    0
`define BFIU_ST_CYC_MSB    3
`define BFIU_ST_EXT_BIT    4
`define BFIU_ST_BUSY_BIT   31

// Status flag positions
`define BFIU_FLAG_C        0
`define BFIU_FLAG_Z        1
`define BFIU_FLAG_N        2
`define BFIU_FLAG_V        3
`define BFIU_FLAG_S        4
`define BFIU_FLAG_H        5
`define BFIU_FLAG_T        6
`define BFIU_FLAG_I        7

// Reset values
`define BFIU_OPERAND_RST   8'h00
`define BFIU_IOVAL_RST     8'h00
`define BFIU_STATUS_RST    8'h00

// Cycle counts
`define BFIU_BASE_CYCLES   4'h1
`define BFIU_SRAM_EXTRA    4'h1

// Bus responses
`define BFIU_RESP_OKAY     2'h0
`define BFIU_RESP_SLVERR   2'h2

`endif

// ==== hdl/bfiu_pkg.sv ====
// Types and shared helpers of the bit/flag unit
package bfiu_pkg;

  typedef enum logic [4:0] {
    op_no_operation, op_rotate_left_carry, op_rotate_right_carry, op_arith_shift_right,
    op_nibble_swap, op_generic_flag_raise, op_generic_flag_lower, op_io_bit_raise,
    op_io_bit_lower, op_bit_to_transfer_flag, op_transfer_flag_to_bit,
    op_overflow_flag_raise, op_overflow_flag_lower, op_half_carry_raise,
    op_half_carry_lower, op_signed_flag_raise, op_signed_flag_lower, op_carry_raise,
    op_carry_lower, op_negative_raise, op_negative_lower, op_zero_raise, op_zero_lower,
    op_global_irq_on, op_global_irq_off, op_transfer_raise, op_transfer_lower,
    op_break_point, op_sleep_enter, op_watchdog_restart
  } bfiu_op_type;

  typedef enum logic [0:0] {st_idle, st_exec} bfiu_state_type;

  // Put one bit of a byte, all others kept
  function automatic logic [7:0] bit_put(input logic [7:0] v, input logic [2:0] idx,
                                         input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction

endpackage

// ==== hdl/bfiu_alu_if.sv ====
// Operand and result bundle between the sequencer and the execution logic
`timescale 1ns/1ns
interface bfiu_alu_if;
  bfiu_pkg::bfiu_op_type op;
  logic [2:0]            bit_sel;
  logic [7:0]            operand;
  logic [7:0]            io_val;
  logic [7:0]            flags_in;
  logic [7:0]            res;
  logic [7:0]            io_res;
  logic [7:0]            flags_out;

  modport core (output op, bit_sel, operand, io_val, flags_in,
                input  res, io_res, flags_out);
  modport alu  (input  op, bit_sel, operand, io_val, flags_in,
                output res, io_res, flags_out);
endinterface

// ==== hdl/bfiu_alu.sv ====
// Combinational execution of the bit, shift and flag instructions
`timescale 1ns/1ns
`include "bfiu_regs.svh"
module bfiu_alu
(
  bfiu_alu_if.alu a
);

  // Common flag update of the shift group; V = N ^ C, S = N ^ V
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r,
                                             input logic c);
    logic [7:0] o;
    o = f;
    o[`BFIU_FLAG_C] = c;
    o[`BFIU_FLAG_Z] = (r == 8'h00);
    o[`BFIU_FLAG_N] = r[7];
    o[`BFIU_FLAG_V] = r[7] ^ c;
    o[`BFIU_FLAG_S] = r[7] ^ (r[7] ^ c);
    return o;
  endfunction

  // Defaults keep everything; each op touches only what it owns
  always_comb
  begin
    a.res       = a.operand;
    a.io_res    = a.io_val;
    a.flags_out = a.flags_in;
    case (a.op)
      bfiu_pkg::op_rotate_left_carry:
      begin
        a.res       = {a.operand[6:0], a.flags_in[`BFIU_FLAG_C]};
        a.flags_out = shift_flags(a.flags_in, {a.operand[6:0], a.flags_in[`BFIU_FLAG_C]},
                                  a.operand[7]);
        a.flags_out[`BFIU_FLAG_H] = a.operand[3];
      end
      bfiu_pkg::op_rotate_right_carry:
      begin
        a.res       = {a.flags_in[`BFIU_FLAG_C], a.operand[7:1]};
        a.flags_out = shift_flags(a.flags_in, {a.flags_in[`BFIU_FLAG_C], a.operand[7:1]},
                                  a.operand[0]);
      end
      bfiu_pkg::op_arith_shift_right:
      begin
        a.res       = {a.operand[7], a.operand[7:1]};
        a.flags_out = shift_flags(a.flags_in, {a.operand[7], a.operand[7:1]}, a.operand[0]);
      end
      bfiu_pkg::op_nibble_swap:          a.res = {a.operand[3:0], a.operand[7:4]};
      bfiu_pkg::op_generic_flag_raise:   a.flags_out = bfiu_pkg::bit_put(a.flags_in, a.bit_sel, 1'b1);
      bfiu_pkg::op_generic_flag_lower:   a.flags_out = bfiu_pkg::bit_put(a.flags_in, a.bit_sel, 1'b0);
      bfiu_pkg::op_io_bit_raise:         a.io_res = bfiu_pkg::bit_put(a.io_val, a.bit_sel, 1'b1);
      bfiu_pkg::op_io_bit_lower:         a.io_res = bfiu_pkg::bit_put(a.io_val, a.bit_sel, 1'b0);
      bfiu_pkg::op_bit_to_transfer_flag: a.flags_out[`BFIU_FLAG_T] = a.operand[a.bit_sel];
      bfiu_pkg::op_transfer_flag_to_bit:
        a.res = bfiu_pkg::bit_put(a.operand, a.bit_sel, a.flags_in[`BFIU_FLAG_T]);
      bfiu_pkg::op_overflow_flag_raise:  a.flags_out[`BFIU_FLAG_V] = 1'b1;
      bfiu_pkg::op_overflow_flag_lower:  a.flags_out[`BFIU_FLAG_V] = 1'b0;
      bfiu_pkg::op_half_carry_raise:     a.flags_out[`BFIU_FLAG_H] = 1'b1;
      bfiu_pkg::op_half_carry_lower:     a.flags_out[`BFIU_FLAG_H] = 1'b0;
      bfiu_pkg::op_signed_flag_raise:    a.flags_out[`BFIU_FLAG_S] = 1'b1;
      bfiu_pkg::op_signed_flag_lower:    a.flags_out[`BFIU_FLAG_S] = 1'b0;
      bfiu_pkg::op_carry_raise:          a.flags_out[`BFIU_FLAG_C] = 1'b1;
      bfiu_pkg::op_carry_lower:          a.flags_out[`BFIU_FLAG_C] = 1'b0;
      bfiu_pkg::op_negative_raise:       a.flags_out[`BFIU_FLAG_N] = 1'b1;
      bfiu_pkg::op_negative_lower:       a.flags_out[`BFIU_FLAG_N] = 1'b0;
      bfiu_pkg::op_zero_raise:           a.flags_out[`BFIU_FLAG_Z] = 1'b1;
      bfiu_pkg::op_zero_lower:           a.flags_out[`BFIU_FLAG_Z] = 1'b0;
      bfiu_pkg::op_global_irq_on:        a.flags_out[`BFIU_FLAG_I] = 1'b1;
      bfiu_pkg::op_global_irq_off:       a.flags_out[`BFIU_FLAG_I] = 1'b0;
      bfiu_pkg::op_transfer_raise:       a.flags_out[`BFIU_FLAG_T] = 1'b1;
      bfiu_pkg::op_transfer_lower:       a.flags_out[`BFIU_FLAG_T] = 1'b0;
      default:                           a.res = a.operand; // No-op, break, sleep, restart
    endcase
  end

endmodule // bfiu_alu

// ==== hdl/bfiu_top.sv ====
// Bit and flag instruction unit behind an AXI4-Lite register slave
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "bfiu_regs.svh"
module bfiu_top
(
  input  wire  logic        sys_clk,
  input  wire  logic        reset,
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready
);

  // Byte-lane merge of a bus write into a register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  bfiu_alu_if alu_bus ();

  logic                      awready_r,  awready_nxt;
  logic                      wready_r,   wready_nxt;
  logic                      bvalid_r,   bvalid_nxt;
  logic [1:0]                bresp_r,    bresp_nxt;
  logic                      arready_r,  arready_nxt;
  logic                      rvalid_r,   rvalid_nxt;
  logic [1:0]                rresp_r,    rresp_nxt;
  logic [31:0]               rdata_r,    rdata_nxt;
  logic                      aw_full_r,  aw_full_nxt;
  logic [7:0]                awaddr_r,   awaddr_nxt;
  logic                      w_full_r,   w_full_nxt;
  logic [31:0]               wdata_r,    wdata_nxt;
  logic [3:0]                wstrb_r,    wstrb_nxt;
  bfiu_pkg::bfiu_op_type     op_r,       op_nxt;
  logic [2:0]                bit_r,      bit_nxt;
  logic                      sram_r,     sram_nxt;
  logic                      ext_r,      ext_nxt;
  logic [7:0]                operand_r,  operand_nxt;
  logic [7:0]                ioval_r,    ioval_nxt;
  logic [7:0]                flag_r,     flag_nxt;
  bfiu_pkg::bfiu_state_type  state_r,    state_nxt;
  logic [3:0]                cnt_r,      cnt_nxt;
  logic [3:0]                cycles_r,   cycles_nxt;
  logic                      uncount_r,  uncount_nxt;
  logic                      wr_fire;
  logic                      commit;
  logic                      cmd_go;
  logic [31:0]               cmd_img;
  logic [31:0]               wr_val;
  logic [31:0]               state_img;

  // Operands to the execution logic
  assign alu_bus.op       = op_r;
  assign alu_bus.bit_sel  = bit_r;
  assign alu_bus.operand  = operand_r;
  assign alu_bus.io_val   = ioval_r;
  assign alu_bus.flags_in = flag_r;

  bfiu_alu u_alu
  (
    .a (alu_bus.alu)
  );

  // Register images as seen by the bus
  assign cmd_img = {18'h0, ext_r, sram_r, 1'b0, bit_r, 3'h0, op_r};
  assign state_img = {(state_r == bfiu_pkg::st_exec), 26'h0, uncount_r, cycles_r};
  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign commit  = (state_r == bfiu_pkg::st_exec) && (cnt_r == 4'h0);
  assign cmd_go  = wr_fire && (awaddr_r == `BFIU_CMD_OFS) && (state_r == bfiu_pkg::st_idle);

  // Write address and data are taken apart, in either order, then joined
  always_comb
  begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    aw_full_nxt = aw_full_r;
    awaddr_nxt  = awaddr_r;
    w_full_nxt  = w_full_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && awready_r)
    begin
      aw_full_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_full_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      wready_nxt = 1'b0;
    end
    if (wr_fire)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (awaddr_r > `BFIU_STATE_OFS || awaddr_r[1:0] != 2'h0) ?
                    `BFIU_RESP_SLVERR : `BFIU_RESP_OKAY;
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
  end

  // Read side: one read in flight, answer one edge after the address
  always_comb
  begin
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = `BFIU_RESP_OKAY;
      case (s_axi_araddr)
        `BFIU_CMD_OFS:     rdata_nxt = cmd_img;
        `BFIU_OPERAND_OFS: rdata_nxt = {24'h0, operand_r};
        `BFIU_IOVAL_OFS:   rdata_nxt = {24'h0, ioval_r};
        `BFIU_STATUS_OFS:  rdata_nxt = {24'h0, flag_r};
        `BFIU_STATE_OFS:   rdata_nxt = state_img;
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = `BFIU_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // Command sequencing; software writes while busy are dropped so a commit never races them
  always_comb
  begin
    wr_val      = 32'h0;
    op_nxt      = op_r;
    bit_nxt     = bit_r;
    sram_nxt    = sram_r;
    ext_nxt     = ext_r;
    operand_nxt = operand_r;
    ioval_nxt   = ioval_r;
    flag_nxt    = flag_r;
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    cycles_nxt  = cycles_r;
    uncount_nxt = uncount_r;
    case (state_r)
      bfiu_pkg::st_idle:
      begin
        if (wr_fire)
        begin
          case (awaddr_r)
            `BFIU_CMD_OFS:
            begin
              wr_val   = lane_merge(cmd_img, wdata_r, wstrb_r);
              op_nxt   = bfiu_pkg::bfiu_op_type'(wr_val[`BFIU_CMD_OP_MSB:`BFIU_CMD_OP_LSB]);
              bit_nxt  = wr_val[`BFIU_CMD_BIT_MSB:`BFIU_CMD_BIT_LSB];
              sram_nxt = wr_val[`BFIU_CMD_SRAM_BIT];
              ext_nxt  = wr_val[`BFIU_CMD_EXT_BIT];
              // Base count, one more for internal static RAM
              cnt_nxt  = `BFIU_BASE_CYCLES - 4'h1 +
                         (wr_val[`BFIU_CMD_SRAM_BIT] ? `BFIU_SRAM_EXTRA : 4'h0);
              state_nxt = bfiu_pkg::st_exec;
            end
            `BFIU_OPERAND_OFS:
            begin
              wr_val      = lane_merge({24'h0, operand_r}, wdata_r, wstrb_r);
              operand_nxt = wr_val[7:0];
            end
            `BFIU_IOVAL_OFS:
            begin
              wr_val    = lane_merge({24'h0, ioval_r}, wdata_r, wstrb_r);
              ioval_nxt = wr_val[7:0];
            end
            `BFIU_STATUS_OFS:
            begin
              wr_val   = lane_merge({24'h0, flag_r}, wdata_r, wstrb_r);
              flag_nxt = wr_val[7:0];
            end
            default: wr_val = 32'h0;
          endcase
        end
      end
      bfiu_pkg::st_exec:
      begin
        if (cnt_r == 4'h0)
        begin
          operand_nxt = alu_bus.res;
          ioval_nxt   = alu_bus.io_res;
          flag_nxt    = alu_bus.flags_out;
          cycles_nxt  = `BFIU_BASE_CYCLES + (sram_r ? `BFIU_SRAM_EXTRA : 4'h0);
          uncount_nxt = ext_r; // External access: the count above does not hold
          state_nxt   = bfiu_pkg::st_idle;
        end
        else
          cnt_nxt = cnt_r - 4'h1;
      end
      default: state_nxt = bfiu_pkg::st_idle;
    endcase
  end

  // All state registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `BFIU_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `BFIU_RESP_OKAY;
      rdata_r   <= 32'h0;
      aw_full_r <= 1'b0;
      awaddr_r  <= 8'h00;
      w_full_r  <= 1'b0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      op_r      <= bfiu_pkg::op_no_operation;
      bit_r     <= 3'h0;
      sram_r    <= 1'b0;
      ext_r     <= 1'b0;
      operand_r <= `BFIU_OPERAND_RST;
      ioval_r   <= `BFIU_IOVAL_RST;
      flag_r    <= `BFIU_STATUS_RST;
      state_r   <= bfiu_pkg::st_idle;
      cnt_r     <= 4'h0;
      cycles_r  <= 4'h0;
      uncount_r <= 1'b0;
    end
    else
    begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      aw_full_r <= aw_full_nxt;
      awaddr_r  <= awaddr_nxt;
      w_full_r  <= w_full_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      op_r      <= op_nxt;
      bit_r     <= bit_nxt;
      sram_r    <= sram_nxt;
      ext_r     <= ext_nxt;
      operand_r <= operand_nxt;
      ioval_r   <= ioval_nxt;
      flag_r    <= flag_nxt;
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      cycles_r  <= cycles_nxt;
      uncount_r <= uncount_nxt;
    end
  end

  // Bus outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // Checks on committed results and on command cycle timing
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  AST_ROTATE_LEFT: assert property (commit && op_r == bfiu_pkg::op_rotate_left_carry |=>
      operand_r == {$past(operand_r[6:0]), $past(flag_r[`BFIU_FLAG_C])} &&
      flag_r[`BFIU_FLAG_C] == $past(operand_r[7]) && flag_r[`BFIU_FLAG_H] == $past(operand_r[3]))
    else $error("rotate left result or flags wrong");
  AST_ROTATE_RIGHT: assert property (commit && op_r == bfiu_pkg::op_rotate_right_carry |=>
      operand_r == {$past(flag_r[`BFIU_FLAG_C]), $past(operand_r[7:1])} &&
      flag_r[`BFIU_FLAG_C] == $past(operand_r[0]) && flag_r[`BFIU_FLAG_Z] == (operand_r == 8'h00))
    else $error("rotate right result or flags wrong");
  AST_IO_RAISE: assert property (commit && op_r == bfiu_pkg::op_io_bit_raise |=>
      ioval_r[$past(bit_r)] && flag_r == $past(flag_r))
    else $error("I/O bit not raised or flags moved");
  AST_IO_LOWER: assert property (commit && op_r == bfiu_pkg::op_io_bit_lower |=>
      !ioval_r[$past(bit_r)] && flag_r == $past(flag_r))
    else $error("I/O bit not lowered or flags moved");
  AST_TO_TRANSFER: assert property (commit && op_r == bfiu_pkg::op_bit_to_transfer_flag |=>
      flag_r[`BFIU_FLAG_T] == $past(operand_r[bit_r]) && flag_r[5:0] == $past(flag_r[5:0]))
    else $error("transfer flag store wrong");
  AST_FROM_TRANSFER: assert property (commit && op_r == bfiu_pkg::op_transfer_flag_to_bit |=>
      operand_r[$past(bit_r)] == $past(flag_r[`BFIU_FLAG_T]) && flag_r == $past(flag_r))
    else $error("transfer flag load wrong");
  AST_OVERFLOW_SET: assert property (commit && op_r == bfiu_pkg::op_overflow_flag_raise |=>
      flag_r == ($past(flag_r) | 8'h08))
    else $error("overflow raise wrong");
  AST_OVERFLOW_CLR: assert property (commit && op_r == bfiu_pkg::op_overflow_flag_lower |=>
      flag_r == ($past(flag_r) & 8'hf7))
    else $error("overflow lower wrong");
  AST_SRAM_CYCLES: assert property (cmd_go && wdata_r[`BFIU_CMD_SRAM_BIT] && wstrb_r[1] |=>
      !commit ##1 commit ##1 cycles_r == 4'h2)
    else $error("internal RAM access did not take one extra cycle");
  AST_PLAIN_CYCLE: assert property (cmd_go && !wdata_r[`BFIU_CMD_SRAM_BIT] && wstrb_r[1] |=>
      commit ##1 state_r == bfiu_pkg::st_idle)
    else $error("plain instruction did not finish in one cycle");
  AST_SWAP: assert property (commit && op_r == bfiu_pkg::op_nibble_swap |=>
      operand_r == {$past(operand_r[3:0]), $past(operand_r[7:4])} && flag_r == $past(flag_r))
    else $error("nibble swap wrong");

  COV_ROTATE: cover property (commit && op_r == bfiu_pkg::op_rotate_left_carry);
  COV_SRAM:   cover property (cmd_go ##1 !commit ##1 commit);
  COV_IOBIT:  cover property (commit && op_r == bfiu_pkg::op_io_bit_raise);
  COV_REFUSE: cover property (wr_fire && state_r == bfiu_pkg::st_exec);

endmodule // bfiu_top

// ==== verif/bfiu_host.sv ====
// AXI4-Lite host model standing in for the core side of the bit/flag unit
`timescale 1ns/1ns
module bfiu_host
(
  input  wire logic        sys_clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Quiet bus at time zero
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
  initial {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 52'h0;

  // Write: AW and W together, each dropped once taken; no fixed latency assumed
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata  <= d;
    s_axi_wstrb  <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wdata <= ~d;  // Stale data never looks valid
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read: hold AR until taken, rready until rvalid seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    {r, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
endmodule // bfiu_host

// ==== verif/tb.sv ====
// Self-checking bench of the bit/flag unit through its register bus
`timescale 1ns/1ns
`include "bfiu_regs.svh"
module tb;
  logic        sys_clk, reset, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [7:0]  aa, ra, d, io, f;
  logic [31:0] wd, rd_d, st;
  logic [3:0]  ws;
  logic [2:0]  k;
  logic [1:0]  bresp, rresp, rsp;
  logic [23:0] ex;
  int          n_fail = 0, total_checks = 0, cyc = 0, n;
  logic [2:0]  fpos [8] = '{3'h3, 3'h5, 3'h4, 3'h0, 3'h2, 3'h1, 3'h7, 3'h6};

  bfiu_top dut
  (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
  );
  bfiu_host host
  (
    .sys_clk(sys_clk), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
  );

  // Reference result of one instruction as {operand, io, flags}
  function automatic logic [23:0] model(input logic [4:0] op, input logic [2:0] k,
                                        input logic [7:0] d, input logic [7:0] io,
                                        input logic [7:0] f);
    logic [7:0] r;
    logic       c;
    r = d;
    c = d[0];
    case (op)
      5'h01: {c, r, f[5]} = {d, f[0], d[3]};
      5'h02: r = {f[0], d[7:1]};
      5'h03: r = {d[7], d[7:1]};
      5'h04: r = {d[3:0], d[7:4]};
      5'h05: f[k] = 1'b1;
      5'h06: f[k] = 1'b0;
      5'h07: io[k] = 1'b1;
      5'h08: io[k] = 1'b0;
      5'h09: f[6] = d[k];
      5'h0a: r[k] = f[6];
      // Odd codes raise, even codes lower one dedicated flag
      default: if (op > 5'h0a && op < 5'h1b) f[fpos[(op - 5'h0b) >> 1]] = op[0];
    endcase
    if (op > 5'h00 && op < 5'h04) f[4:0] = {c, r[7] ^ c, r[7], r == 8'h00, c};
    return {r, io, f};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the two thousand or so cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    reset = 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset state, then unmapped and misaligned reads and an unmapped write
    for (int i = 0; i < 4; i++)
    begin
      host.rd(8'(4 + 4 * i), st, rsp);
      chk({rsp, st}, 34'h0);
    end
    host.rd(8'h14, st, rsp);
    chk({rsp, st}, {`BFIU_RESP_SLVERR, 32'h0});
    host.rd(8'h02, st, rsp);
    chk({rsp, st}, {`BFIU_RESP_SLVERR, 32'h0});
    host.wr(8'h20, 32'h0000_00ff, rsp);
    chk({32'h0, rsp}, {32'h0, `BFIU_RESP_SLVERR});
    // Every op code, internal RAM and external flags both ways
    for (int v = 0; v < 2; v++)
      for (int op = 0; op < 32; op++)
      begin
        {d, io, f, k} = {v ? 8'h01 : 8'h96, 8'h3c ^ {8{v[0]}}, v ? 8'h5a : 8'ha5, 3'(op + v)};
        host.wr(`BFIU_OPERAND_OFS, {24'h0, d}, rsp);
        host.wr(`BFIU_IOVAL_OFS, {24'h0, io}, rsp);
        host.wr(`BFIU_STATUS_OFS, {24'h0, f}, rsp);
        host.wr(`BFIU_CMD_OFS, {18'h0, v[0] & op[0], v[0], 1'b0, k, 3'h0, 5'(op)}, rsp);
        n = 0;
        do host.rd(`BFIU_STATE_OFS, st, rsp); while (st[31] !== 1'b0 && n++ < 20);
        chk({rsp, st}, {29'h0, v[0] & op[0], 4'(1 + v)});
        ex = model(5'(op), k, d, io, f);
        for (int i = 0; i < 3; i++)
        begin
          host.rd(8'(4 + 4 * i), st, rsp);
          chk({rsp, st}, {26'h0, ex[23 - 8 * i -: 8]});
        end
      end
    host.wr(`BFIU_STATE_OFS, 32'hffff_ffff, rsp);
    host.rd(`BFIU_STATE_OFS, st, rsp);
    chk({rsp, st}, {29'h0, 1'b1, 4'h2});
    finish_test();
  end
endmodule // tb
